// ### src/gpx_port_top.sv
// Purpose: two groups of eight gpio ports with pulls, filter, function mux and edge flags
// Assumes: apb slave on ref_clk, pins and slow clock arrive asynchronously
// Notes: zero wait-state apb, pin outputs follow registers one cycle later
// Overview of operation
// - Two groups, zero and one, of eight individually controlled ports each.
// - Reset: group zero floats, group one drives low, pulls and inputs off, gpio.
// - Reset configuration holds until software writes new values.
// - Each port has a two-bit selector among four peripheral functions.
// - Function enable 0 keeps gpio, 1 routes to the selected peripheral.
// - With a peripheral enabled, the peripheral drives and enables the pin.
// - Gpio with output enabled drives the pin from the output data bit.
// - Reading the data register returns the pin level, 1 high, for ports with input enabled, else 0.
// - Output enabled forces pulls off; otherwise pull enable and direction apply.
// - Pull direction and pull enable are chosen per port.
// - Per-port filter enable passes the input through the filter.
// - Filter samples over 2 to 3 gpio clock periods, rejecting shorter pulses.
// - Shared gpio clock comes from a source select bit and four-bit divider.
// - Clock settings change only after key 0x0096; any other key relocks.
// - With the filter off, the input works without the gpio clock.
// - Flag sets on the selected edge of a gpio port, 1 falling, 0 rising; write 1 clears.
// - A port requests an interrupt only when flagged and enabled.
// - Group summary sets for enabled flagged ports and clears with the flag.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
module gpx_port_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [6:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins, group zero in bits 7:0, group one in bits 15:8
	input wire logic [gpx_pkg::NUM_PORTS-1:0] padIn,
	output logic [gpx_pkg::NUM_PORTS-1:0] padOut,
	output logic [gpx_pkg::NUM_PORTS-1:0] padOe,
	output logic [gpx_pkg::NUM_PORTS-1:0] pullUpEn,
	output logic [gpx_pkg::NUM_PORTS-1:0] pullDownEn,
	// alternate gpio clock source pin
	input wire logic slowClkIn,
	// peripherals, function f of port p at index p*4+f
	input wire logic [gpx_pkg::NUM_PORTS*gpx_pkg::NUM_FUNCS-1:0] periphOut,
	input wire logic [gpx_pkg::NUM_PORTS*gpx_pkg::NUM_FUNCS-1:0] periphOe,
	output logic [gpx_pkg::NUM_PORTS-1:0] periphIn,
	// per-group interrupt requests
	output logic [gpx_pkg::NUM_GROUPS-1:0] portIrq
);
	import gpx_pkg::*;

	// configuration registers, port p of group g at bit g*8+p
	logic [15:0] inEnReg, outEnReg, pullEnReg, pullDirReg, funcEnReg, outValReg, filtEnReg, irqEnReg, edgeSelReg;
	logic [15:0] irqFlagReg;
	logic [31:0] funcSelReg;
	logic [DIV_WIDTH-1:0] clkDivReg;
	logic clkSrcReg, unlockedReg;
	logic [15:0] syncAReg, syncBReg, prevInReg;
	logic slowAReg, slowBReg, slowCReg;
	logic [15:0] divCntReg;
	logic [15:0] filtered, inVal, edgeEvt, flagClr, padOutNext, padOeNext, puNext, pdNext, periphInNext;
	logic tick, srcTick;
	logic [15:0] divMask;

	// apb decode
	logic setup, wrAcc;
	logic grp, inGroupSpace, mapped;
	logic [2:0] idx;
	logic [31:0] rdNext;
	assign setup = psel && !penable;
	assign wrAcc = psel && penable && pwrite && pready;
	assign grp = paddr[5];
	assign idx = paddr[4:2];
	assign inGroupSpace = (paddr < OFS_CLOCK_CONFIG) && (paddr[1:0] == 2'b00);
	assign mapped = inGroupSpace || paddr == OFS_CLOCK_CONFIG || paddr == OFS_WRITE_GUARD
		|| paddr == OFS_GROUP_SUMMARY;

	// write strobe for one group register
	function automatic logic wrGroup(input logic g, input logic [2:0] i);
		return wrAcc && inGroupSpace && grp == g && idx == i;
	endfunction

	// read mux
	always_comb begin
		rdNext = RST_ZERO32;
		if (inGroupSpace) begin
			unique case (idx)
				IDX_IO_ENABLE: rdNext = {16'h0000, outEnReg[grp*8+:8], inEnReg[grp*8+:8]};
				IDX_RESISTOR: rdNext = {16'h0000, pullDirReg[grp*8+:8], pullEnReg[grp*8+:8]};
				IDX_FUNC_ENABLE: rdNext = {24'h00_0000, funcEnReg[grp*8+:8]};
				IDX_FUNC_SELECT: rdNext = {16'h0000, funcSelReg[grp*16+:16]};
				IDX_DATA: rdNext = {16'h0000, inVal[grp*8+:8], outValReg[grp*8+:8]};
				IDX_FILTER_ENABLE: rdNext = {24'h00_0000, filtEnReg[grp*8+:8]};
				IDX_IRQ_CTRL: rdNext = {16'h0000, edgeSelReg[grp*8+:8], irqEnReg[grp*8+:8]};
				IDX_IRQ_FLAG: rdNext = {24'h00_0000, irqFlagReg[grp*8+:8]};
			endcase
		end else if (paddr == OFS_CLOCK_CONFIG) begin
			rdNext = {27'h000_0000, clkSrcReg, clkDivReg};
		end else if (paddr == OFS_WRITE_GUARD) begin
			rdNext = {31'h0000_0000, unlockedReg};
		end else if (paddr == OFS_GROUP_SUMMARY) begin
			rdNext = {30'h0000_0000, portIrq};
		end
	end

	// apb answer: ready in the access cycle, error for unmapped addresses
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= RST_ZERO32;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= (setup && !pwrite) ? rdNext : RST_ZERO32;
		end
	end

	// per-group configuration registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			inEnReg <= RST_ZERO16;
			outEnReg <= RST_OUTPUT_ENABLE;
			pullEnReg <= RST_ZERO16;
			pullDirReg <= RST_ZERO16;
			funcEnReg <= RST_ZERO16;
			funcSelReg <= RST_ZERO32;
			outValReg <= RST_ZERO16;
			filtEnReg <= RST_ZERO16;
			irqEnReg <= RST_ZERO16;
			edgeSelReg <= RST_ZERO16;
		end else begin
			for (int g = 0; g < NUM_GROUPS; g++) begin
				// values only change on a software write
				if (wrGroup(g[0], IDX_IO_ENABLE)) begin
					inEnReg[g*8+:8] <= pwdata[7:0];
					outEnReg[g*8+:8] <= pwdata[POS_HIGH_BYTE+:8];
				end
				if (wrGroup(g[0], IDX_RESISTOR)) begin
					pullEnReg[g*8+:8] <= pwdata[7:0];
					pullDirReg[g*8+:8] <= pwdata[POS_HIGH_BYTE+:8];
				end
				if (wrGroup(g[0], IDX_FUNC_ENABLE)) begin
					funcEnReg[g*8+:8] <= pwdata[7:0];
				end
				if (wrGroup(g[0], IDX_FUNC_SELECT)) begin
					funcSelReg[g*16+:16] <= pwdata[15:0];
				end
				if (wrGroup(g[0], IDX_DATA)) begin
					outValReg[g*8+:8] <= pwdata[7:0];
				end
				if (wrGroup(g[0], IDX_FILTER_ENABLE)) begin
					filtEnReg[g*8+:8] <= pwdata[7:0];
				end
				if (wrGroup(g[0], IDX_IRQ_CTRL)) begin
					irqEnReg[g*8+:8] <= pwdata[7:0];
					edgeSelReg[g*8+:8] <= pwdata[POS_HIGH_BYTE+:8];
				end
			end
		end
	end

	// write guard and protected gpio clock settings
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			unlockedReg <= 1'b0;
			clkSrcReg <= 1'b0;
			clkDivReg <= '0;
		end else begin
			if (wrAcc && paddr == OFS_WRITE_GUARD) begin
				unlockedReg <= pwdata[15:0] == UNLOCK_KEY;
			end
			if (wrAcc && paddr == OFS_CLOCK_CONFIG && unlockedReg) begin
				clkDivReg <= pwdata[DIV_WIDTH-1:0];
				clkSrcReg <= pwdata[POS_CLOCK_SOURCE];
			end
		end
	end

	// gpio tick: source is ref_clk or the synchronised slow clock, divided by 2^div
	assign srcTick = clkSrcReg ? (slowBReg && !slowCReg) : 1'b1;
	assign divMask = 16'(({1'b0, 16'h0001} << clkDivReg) - 17'h0_0001);
	assign tick = srcTick && ((divCntReg & divMask) == divMask);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			slowAReg <= 1'b0;
			slowBReg <= 1'b0;
			slowCReg <= 1'b0;
			divCntReg <= RST_ZERO16;
		end else begin
			slowAReg <= slowClkIn;
			slowBReg <= slowAReg;
			slowCReg <= slowBReg;
			divCntReg <= srcTick ? divCntReg + 16'h0001 : divCntReg;
		end
	end

	// two-stage pin synchronisers and previous input for edge detection
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			syncAReg <= RST_ZERO16;
			syncBReg <= RST_ZERO16;
			prevInReg <= RST_ZERO16;
		end else begin
			syncAReg <= padIn;
			syncBReg <= syncAReg;
			prevInReg <= inVal;
		end
	end

	// per-port datapath
	assign flagClr = (wrAcc && inGroupSpace && idx == IDX_IRQ_FLAG) ? (grp ? {pwdata[7:0], 8'h00} : {8'h00, pwdata[7:0]})
		: RST_ZERO16;
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		logic [1:0] fn;
		assign fn = funcSelReg[p*2+:2];
		gpx_glitch_filter u_filter (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.enable(filtEnReg[p]),
			.tick(tick),
			.din(syncBReg[p]),
			.dout(filtered[p])
		);
		assign inVal[p] = inEnReg[p] & filtered[p];
		// falling edge when edge select is 1, rising otherwise, gpio ports only
		assign edgeEvt[p] = !funcEnReg[p] && (edgeSelReg[p] ? (prevInReg[p] && !inVal[p])
			: (!prevInReg[p] && inVal[p]));
		assign padOeNext[p] = funcEnReg[p] ? periphOe[p*NUM_FUNCS+fn] : outEnReg[p];
		assign padOutNext[p] = funcEnReg[p] ? periphOut[p*NUM_FUNCS+fn] : outValReg[p];
		assign puNext[p] = pullEnReg[p] && pullDirReg[p] && !padOeNext[p];
		assign pdNext[p] = pullEnReg[p] && !pullDirReg[p] && !padOeNext[p];
		assign periphInNext[p] = funcEnReg[p] && syncBReg[p];
	end

	// registered pin and peripheral outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			padOe <= RST_OUTPUT_ENABLE;
			padOut <= RST_ZERO16;
			pullUpEn <= RST_ZERO16;
			pullDownEn <= RST_ZERO16;
			periphIn <= RST_ZERO16;
		end else begin
			padOe <= padOeNext;
			padOut <= padOutNext;
			pullUpEn <= puNext;
			pullDownEn <= pdNext;
			periphIn <= periphInNext;
		end
	end

	// edge flags, a new edge wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irqFlagReg <= RST_ZERO16;
		end else begin
			irqFlagReg <= (irqFlagReg & ~flagClr) | edgeEvt;
		end
	end

	// group summary and request, only enabled flags count
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			portIrq <= '0;
		end else begin
			for (int g = 0; g < NUM_GROUPS; g++) begin
				portIrq[g] <= |(irqFlagReg[g*8+:8] & irqEnReg[g*8+:8]);
			end
		end
	end

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_reset_state: assert property (!$past(rst_n) |-> padOe == RST_OUTPUT_ENABLE
		&& padOut == RST_ZERO16 && pullUpEn == RST_ZERO16 && pullDownEn == RST_ZERO16)
		else $error("pins not in reset configuration after reset");
	a_guard_locked: assert property ((wrAcc && paddr == OFS_CLOCK_CONFIG && !unlockedReg)
		|=> $stable(clkDivReg) && $stable(clkSrcReg))
		else $error("clock settings changed while locked");
	a_pull_vs_out: assert property (((pullUpEn | pullDownEn) & padOe) == RST_ZERO16)
		else $error("pull active on a driven pin");
	a_gpio_drive: assert property (1'b1 |=>
		((padOut ^ $past(outValReg)) & $past(~funcEnReg & outEnReg)) == RST_ZERO16)
		else $error("gpio pin does not follow output data");
	a_periph_route: assert property (funcEnReg[2] |=>
		padOe[2] == $past(periphOe[2*NUM_FUNCS+funcSelReg[5:4]])
		&& padOut[2] == $past(periphOut[2*NUM_FUNCS+funcSelReg[5:4]]))
		else $error("peripheral does not own its pin");
	a_gated_quiet: assert property ((inEnReg == RST_ZERO16 && $past(inEnReg) == RST_ZERO16)
		|-> edgeEvt == RST_ZERO16)
		else $error("edge seen on a port with input disabled");
	a_set_wins: assert property ((edgeEvt != RST_ZERO16) |=> (irqFlagReg & $past(edgeEvt)) == $past(edgeEvt))
		else $error("edge lost against flag clear");
	a_irq_request: assert property (1'b1 |=>
		portIrq[1] == |($past(irqFlagReg[15:8]) & $past(irqEnReg[15:8])))
		else $error("group one request mismatch");
	a_summary_clear: assert property ((wrAcc && inGroupSpace && idx == IDX_IRQ_FLAG && !grp
		&& pwdata[7:0] == 8'hFF && edgeEvt[7:0] == 8'h00) |=> ##1 !portIrq[0])
		else $error("summary stays set after flags cleared");
	a_apb_ready: assert property (setup |=> pready ##1 !pready)
		else $error("apb answer not in the access cycle");

	c_flag_set: cover property (edgeEvt != RST_ZERO16 ##1 portIrq != '0);
	c_periph_on: cover property ($rose(funcEnReg[2]));
	c_unlock_cfg: cover property (unlockedReg && wrAcc && paddr == OFS_CLOCK_CONFIG);
	c_filtered_rise: cover property (filtEnReg[10] && $rose(filtered[10]));
endmodule

// ### src/gpx_pkg.sv
// Purpose: shared constants for the two-group gpio port block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: group one registers sit one group stride above group zero
package gpx_pkg;
	localparam int NUM_GROUPS = 2;
	localparam int PORTS_PER_GROUP = 8;
	localparam int NUM_PORTS = NUM_GROUPS * PORTS_PER_GROUP;
	localparam int NUM_FUNCS = 4;
	// per-group register offsets, group g adds g * GROUP_STRIDE
	localparam logic [6:0] GROUP_STRIDE = 7'h20;
	localparam logic [2:0] IDX_IO_ENABLE = 3'h0;
	localparam logic [2:0] IDX_RESISTOR = 3'h1;
	localparam logic [2:0] IDX_FUNC_ENABLE = 3'h2;
	localparam logic [2:0] IDX_FUNC_SELECT = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h4;
	localparam logic [2:0] IDX_FILTER_ENABLE = 3'h5;
	localparam logic [2:0] IDX_IRQ_CTRL = 3'h6;
	localparam logic [2:0] IDX_IRQ_FLAG = 3'h7;
	// common registers
	localparam logic [6:0] OFS_CLOCK_CONFIG = 7'h40;
	localparam logic [6:0] OFS_WRITE_GUARD = 7'h44;
	localparam logic [6:0] OFS_GROUP_SUMMARY = 7'h48;
	// field positions
	localparam int POS_HIGH_BYTE = 8;
	localparam int POS_CLOCK_SOURCE = 4;
	localparam int DIV_WIDTH = 4;
	// reset values
	localparam logic [15:0] RST_OUTPUT_ENABLE = 16'hFF00;
	localparam logic [15:0] RST_ZERO16 = 16'h0000;
	localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;
	localparam logic [15:0] UNLOCK_KEY = 16'h0096;
	// filter needs this many equal samples, spanning 2 to 3 periods
	localparam int FILTER_TAPS = 3;
endpackage

// ### src/gpx_glitch_filter.sv
// Purpose: per-port glitch filter sampled on the shared gpio tick
// Assumes: tick is a one-cycle pulse on ref_clk
// Notes: bypassed combinationally when disabled, so no tick is needed
`timescale 1ns/1ps
module gpx_glitch_filter #(
	parameter int TAPS = gpx_pkg::FILTER_TAPS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// control
	input wire logic enable,
	input wire logic tick,
	// data
	input wire logic din,
	output logic dout
);
	import gpx_pkg::*;
	logic [TAPS-1:0] sampleReg;
	logic heldReg;

	// elaboration check: fewer than two taps cannot reject a glitch
	if (TAPS < 2) begin : g_bad_taps
		$error("filter needs at least two taps");
	end

	// shift samples on each tick, follow input while bypassed
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sampleReg <= '0;
		end else if (!enable) begin
			sampleReg <= {TAPS{din}};
		end else if (tick) begin
			sampleReg <= {sampleReg[TAPS-2:0], din};
		end
	end

	// output changes only once all taps agree, follows input while bypassed
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			heldReg <= 1'b0;
		end else if (!enable) begin
			heldReg <= din;
		end else if (sampleReg == {TAPS{1'b1}}) begin
			heldReg <= 1'b1;
		end else if (sampleReg == {TAPS{1'b0}}) begin
			heldReg <= 1'b0;
		end
	end

	assign dout = enable ? heldReg : din;

	a_filter_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(enable && $past(enable) && $past(enable, 2) && !$past(tick) && !$past(tick, 2)) |-> $stable(heldReg))
		else $error("filtered value moved without a sample tick");
endmodule

// ### dv/gpx_pin_model.sv
// Purpose: far-side pin model resolving each pad from every driver
// Assumes: the bench drives extVal only where extEn is high
// Notes: a pin nobody holds toggles each cycle instead of keeping a level
`timescale 1ns/1ps
module gpx_pin_model (
	// clock
	input wire logic ref_clk,
	// device pad controls
	input wire logic [gpx_pkg::NUM_PORTS-1:0] padOut,
	input wire logic [gpx_pkg::NUM_PORTS-1:0] padOe,
	input wire logic [gpx_pkg::NUM_PORTS-1:0] pullUpEn,
	input wire logic [gpx_pkg::NUM_PORTS-1:0] pullDownEn,
	// external drivers
	input wire logic [gpx_pkg::NUM_PORTS-1:0] extVal,
	input wire logic [gpx_pkg::NUM_PORTS-1:0] extEn,
	// resolved pin levels
	output logic [gpx_pkg::NUM_PORTS-1:0] padIn
);
	import gpx_pkg::*;
	logic [NUM_PORTS-1:0] floatPat;
	// wandering level for undriven, unpulled pins, owned by one process
	initial begin
		floatPat = 16'h5555;
		forever @(posedge ref_clk) floatPat <= ~floatPat;
	end
	// device drive wins, then external drive, then the pull
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (padOe[i]) begin
				padIn[i] = padOut[i];
			end else if (extEn[i]) begin
				padIn[i] = extVal[i];
			end else if (pullUpEn[i] | pullDownEn[i]) begin
				padIn[i] = pullUpEn[i];
			end else begin
				padIn[i] = floatPat[i];
			end
		end
	end
endmodule

// ### dv/gpio_port_with_debounce_mux_test.sv
// Purpose: self-checking bench for the two-group gpio port block
// Assumes: zero wait-state apb, pins resolved by the pin model
// Notes: stimulus changes by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module gpio_port_with_debounce_mux_test;
	import gpx_pkg::*;
	logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, slowClkIn, lastErr, slowRun;
	logic [6:0] paddr;
	logic [31:0] pwdata, prdata, rdVal;
	logic [15:0] padIn, padOut, padOe, pullUpEn, pullDownEn, extVal, extEn, periphIn;
	logic [63:0] periphOut, periphOe;
	logic [1:0] portIrq;
	int num_errors, checked;
	gpx_port_top gpx_port_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn),
		.pullDownEn(pullDownEn), .slowClkIn(slowClkIn), .periphOut(periphOut), .periphOe(periphOe),
		.periphIn(periphIn), .portIrq(portIrq));
	gpx_pin_model gpx_pin_model_i (.ref_clk(ref_clk), .padOut(padOut), .padOe(padOe),
		.pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .extVal(extVal), .extEn(extEn), .padIn(padIn));
	// 125 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// alternate gpio clock source, four ref_clk periods per cycle while slowRun is set
	initial begin
		slowClkIn = 1'b0;
		forever begin
			cyc(2);
			if (slowRun) slowClkIn <= ~slowClkIn;
		end
	end
	// verdict and end of run
	task automatic final_report;
		if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [6:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rdVal = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: apb transfer timed out", $time);
			final_report();
		end
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [6:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdVal, exp);
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 7'h00;
		pwdata = 32'h0000_0000;
		slowRun = 1'b0;
		extVal = 16'h0000;
		extEn = 16'h0000;
		periphOut = 64'h6666_6666_6666_6666;
		periphOe = 64'hDDDD_DDDD_DDDD_DDDD;
		cyc(2);
		rst_n <= 1'b1;
		cyc(1);
		// reset state
		chk(32'(padOe), 32'(RST_OUTPUT_ENABLE));
		chk({padOut, pullUpEn}, 32'h0000_0000);
		chk({pullDownEn, periphIn}, 32'h0000_0000);
		rd(7'h00, 32'h0000_0000);
		rd(7'h20, 32'h0000_FF00);
		rd(7'h08, 32'h0000_0000);
		rd(7'h28, 32'h0000_0000);
		rd(7'h24, 32'h0000_0000);
		cyc(20);
		chk({padOe, padOut}, 32'hFF00_0000);
		// gpio outputs in both groups
		wr(7'h00, 32'h0000_FF00);
		wr(7'h10, 32'h0000_00A5);
		wr(7'h30, 32'h0000_003C);
		cyc(1);
		chk({padOe, padOut}, 32'hFFFF_3CA5);
		rd(7'h10, 32'h0000_00A5);
		wr(7'h00, 32'h0000_FFFF);
		cyc(3);
		rd(7'h10, 32'h0000_A5A5);
		// pulls only on undriven pins
		wr(7'h00, 32'h0000_0F00);
		wr(7'h04, 32'h0000_33FF);
		wr(7'h24, 32'h0000_FFFF);
		cyc(1);
		chk({pullUpEn, pullDownEn}, 32'h0030_00C0);
		// group one as inputs driven from outside
		extEn <= 16'hFF00;
		extVal <= 16'h6900;
		wr(7'h20, 32'h0000_00FF);
		cyc(3);
		rd(7'h30, 32'h0000_693C);
		// edge flags and requests
		wr(7'h3C, 32'h0000_00FF);
		wr(7'h38, 32'h0000_0001);
		extVal[8] <= 1'b0;
		cyc(6);
		chk(32'(portIrq), 32'h0000_0000);
		extVal[8] <= 1'b1;
		cyc(3);
		chk(32'(portIrq), 32'h0000_0000);
		cyc(3);
		chk(32'(portIrq), 32'h0000_0002);
		rd(7'h48, 32'h0000_0002);
		rd(7'h3C, 32'h0000_0001);
		wr(7'h3C, 32'h0000_0001);
		cyc(1);
		chk(32'(portIrq), 32'h0000_0000);
		rd(7'h48, 32'h0000_0000);
		wr(7'h38, 32'h0000_0101);
		extVal[8] <= 1'b0;
		cyc(6);
		chk(32'(portIrq), 32'h0000_0002);
		wr(7'h3C, 32'h0000_0001);
		extVal[9] <= 1'b1;
		cyc(6);
		chk(32'(portIrq), 32'h0000_0000);
		rd(7'h3C, 32'h0000_0002);
		rd(7'h48, 32'h0000_0000);
		wr(7'h3C, 32'h0000_00FF);
		// group zero flags left from the first input enable
		rd(7'h1C, 32'h0000_00A5);
		wr(7'h18, 32'h0000_0001);
		cyc(1);
		chk(32'(portIrq), 32'h0000_0001);
		rd(7'h48, 32'h0000_0001);
		wr(7'h1C, 32'h0000_00FF);
		cyc(1);
		chk(32'(portIrq), 32'h0000_0000);
		rd(7'h1C, 32'h0000_0000);
		// protected gpio clock settings and an unmapped address
		wr(7'h40, 32'h0000_001F);
		rd(7'h40, 32'h0000_0000);
		wr(7'h44, 32'(UNLOCK_KEY));
		rd(7'h44, 32'h0000_0001);
		wr(7'h40, 32'h0000_0013);
		rd(7'h40, 32'h0000_0013);
		wr(7'h44, 32'h0000_0095);
		rd(7'h44, 32'h0000_0000);
		wr(7'h40, 32'h0000_0000);
		rd(7'h40, 32'h0000_0013);
		rd(7'h4C, 32'h0000_0000);
		chk(32'(lastErr), 32'h0000_0001);
		// bypassed filter with the gpio clock stopped
		wr(7'h38, 32'h0000_0004);
		extVal[10] <= 1'b1;
		cyc(1);
		extVal[10] <= 1'b0;
		cyc(6);
		chk(32'(portIrq), 32'h0000_0002);
		wr(7'h3C, 32'h0000_00FF);
		// filter on, tick every cycle
		wr(7'h38, 32'h0000_0000);
		wr(7'h44, 32'(UNLOCK_KEY));
		wr(7'h40, 32'h0000_0000);
		wr(7'h44, 32'h0000_0000);
		wr(7'h34, 32'h0000_0004);
		cyc(8);
		wr(7'h3C, 32'h0000_00FF);
		wr(7'h38, 32'h0000_0004);
		extVal[10] <= 1'b1;
		cyc(1);
		extVal[10] <= 1'b0;
		cyc(8);
		chk(32'(portIrq), 32'h0000_0000);
		extVal[10] <= 1'b1;
		cyc(12);
		chk(32'(portIrq), 32'h0000_0002);
		rd(7'h30, 32'h0000_6E3C);
		// filter on the slow source divided by two: one tick every eight cycles
		slowRun <= 1'b1;
		wr(7'h38, 32'h0000_0000);
		wr(7'h44, 32'(UNLOCK_KEY));
		wr(7'h40, 32'h0000_0011);
		wr(7'h44, 32'h0000_0000);
		wr(7'h3C, 32'h0000_00FF);
		wr(7'h38, 32'h0000_0404);
		extVal[10] <= 1'b0;
		cyc(16);
		extVal[10] <= 1'b1;
		cyc(40);
		chk(32'(portIrq), 32'h0000_0000);
		extVal[10] <= 1'b0;
		cyc(40);
		chk(32'(portIrq), 32'h0000_0002);
		wr(7'h38, 32'h0000_0000);
		// every peripheral function on group zero port 2
		wr(7'h00, 32'h0000_0B00);
		for (int f = 0; f < NUM_FUNCS; f++) begin
			wr(7'h08, 32'h0000_0000);
			wr(7'h0C, 32'(f) << 4);
			wr(7'h08, 32'h0000_0004);
			cyc(6);
			chk(32'({padOe[2], padOut[2], periphIn[2]}),
				32'({periphOe[8+f], periphOut[8+f], periphOe[8+f] & periphOut[8+f]}));
		end
		wr(7'h00, 32'h0000_0F00);
		wr(7'h08, 32'h0000_0000);
		cyc(1);
		chk(32'({padOe[2], padOut[2]}), 32'h0000_0003);
		final_report();
	end
endmodule
